// ===== verilog/abx_pkg.sv
`default_nettype none
package abx_pkg;
    // Bus geometry
    localparam int ABX_AW = 8;
    localparam int ABX_DW = 32;
    // Register byte offsets
    localparam logic [7:0] ABX_OFF_INSTR = 8'h00;
    localparam logic [7:0] ABX_OFF_ACC = 8'h04;
    localparam logic [7:0] ABX_OFF_STATUS = 8'h08;
    localparam logic [7:0] ABX_OFF_PINS = 8'h0C;
    // Status field positions
    localparam int ABX_ST_CARRY = 0;
    localparam int ABX_ST_NIBBLE = 1;
    localparam int ABX_ST_ZERO = 2;
    localparam int ABX_ST_SKIP = 3;
    localparam int ABX_ST_BUSY = 4;
    // Reset values
    localparam logic [7:0] ABX_ACC_RST = 8'h00;
    localparam logic [13:0] ABX_INSTR_RST = 14'h0000;
    // Instruction word layout
    localparam int ABX_IW = 14;
    localparam int ABX_DEST_BIT = 7;
    localparam logic [1:0] ABX_CLS_BYTE = 2'h0;
    localparam logic [1:0] ABX_CLS_BIT = 2'h1;
    localparam logic [1:0] ABX_CLS_LIT = 2'h3;
    localparam logic [3:0] ABX_BYTE_ADD = 4'h7;
    localparam logic [3:0] ABX_BYTE_AND = 4'h5;
    localparam logic [1:0] ABX_BIT_LOW = 2'h0;
    localparam logic [1:0] ABX_BIT_HIGH = 2'h1;
    localparam logic [1:0] ABX_BIT_TST_LOW = 2'h2;
    localparam logic [1:0] ABX_BIT_TST_HIGH = 2'h3;
    localparam logic [2:0] ABX_LIT_ADD = 3'h7;
    localparam logic [3:0] ABX_LIT_AND = 4'h9;
    // AXI responses
    localparam logic [1:0] ABX_RESP_OKAY = 2'h0;
    localparam logic [1:0] ABX_RESP_SLVERR = 2'h2;

    typedef enum {
        ABX_NONE_OP,
        ABX_ADD_IMMEDIATE_OP,
        ABX_AND_IMMEDIATE_OP,
        ABX_ADD_REGISTER_OP,
        ABX_AND_REGISTER_OP,
        ABX_BIT_FORCE_LOW_OP,
        ABX_BIT_FORCE_HIGH_OP,
        ABX_TEST_SKIP_ON_LOW_OP,
        ABX_TEST_SKIP_ON_HIGH_OP
    } abx_op_t;

    typedef enum {ABX_EX_IDLE, ABX_EX_READ} abx_state_t;
endpackage : abx_pkg
`default_nettype wire

// ===== verilog/abx_sync2.sv
`timescale 1ns/100ps
`default_nettype none
module abx_sync2 #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule : abx_sync2
`default_nettype wire

// ===== verilog/abx_exec.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE1: Immediate add sums accumulator and literal into accumulator, updating carry, nibble, zero.
// RULE2: Register add sums accumulator and file register, updating carry, nibble, zero.
// RULE3: Destination bit 0 sends result to accumulator, 1 back to file register.
// RULE4: Immediate AND masks accumulator with literal; only zero flag changes.
// RULE5: Register AND masks accumulator with file register, routed by destination bit.
// RULE6: Bit force low clears one file register bit; flags untouched.
// RULE7: Bit force high sets one file register bit; flags untouched.
// RULE8: Test-skip-on-low discards next instruction when the bit is zero.
// RULE9: Test-skip-on-high discards next instruction when the bit is one.
// RULE10: Operand from the port register comes from sampled pin levels.
// RULE11: The discarded instruction's slot executes as a no-operation.
// RULE12: Zero on zero result; carry from bit 7, nibble carry from bit 3.
module abx_exec
    import abx_pkg::*;
#(
    parameter logic [6:0] PORT_ADDR = 7'h05
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ABX_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ABX_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ABX_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ABX_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [6:0] fr_addr,
    output logic [7:0] fr_wdata,
    output logic fr_we,
    input wire logic [7:0] fr_rdata,
    input wire logic [7:0] port_pins
);
    logic [7:0] pins_sync;
    abx_sync2 #(.W(8)) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_i(port_pins),
        .sync_o(pins_sync)
    );

    // Bus state
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [ABX_AW-1:0] waddr_q, waddr_d;
    logic [ABX_DW-1:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [ABX_DW-1:0] rdata_q, rdata_d;
    // Execution state
    abx_state_t st_q, st_d;
    abx_op_t op_q, op_d;
    logic [ABX_IW-1:0] instr_q, instr_d;
    logic [7:0] acc_q, acc_d;
    logic c_q, c_d, dc_q, dc_d, z_q, z_d, skip_q, skip_d;
    logic [6:0] fr_addr_q, fr_addr_d;
    logic [7:0] fr_wdata_q, fr_wdata_d;
    logic fr_we_q, fr_we_d;

    logic do_write, busy, wr_ok, launch, acc_wr, st_wr;

    function automatic abx_op_t decode(input logic [ABX_IW-1:0] iw);
        abx_op_t op;
        op = ABX_NONE_OP;
        case (iw[13:12])
            ABX_CLS_BYTE: begin
                if (iw[11:8] == ABX_BYTE_ADD) op = ABX_ADD_REGISTER_OP;
                else if (iw[11:8] == ABX_BYTE_AND) op = ABX_AND_REGISTER_OP;
            end
            ABX_CLS_BIT: begin
                case (iw[11:10])
                    ABX_BIT_LOW: op = ABX_BIT_FORCE_LOW_OP;
                    ABX_BIT_HIGH: op = ABX_BIT_FORCE_HIGH_OP;
                    ABX_BIT_TST_LOW: op = ABX_TEST_SKIP_ON_LOW_OP;
                    default: op = ABX_TEST_SKIP_ON_HIGH_OP;
                endcase
            end
            ABX_CLS_LIT: begin
                if (iw[11:9] == ABX_LIT_ADD) op = ABX_ADD_IMMEDIATE_OP;
                else if (iw[11:8] == ABX_LIT_AND) op = ABX_AND_IMMEDIATE_OP;
            end
            default: op = ABX_NONE_OP;
        endcase
        return op;
    endfunction : decode

    assign busy = (st_q != ABX_EX_IDLE);
    assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
    // Writes are refused while an operand fetch is in flight
    assign wr_ok = !busy && (((waddr_q == ABX_OFF_INSTR) && (wstrb_q[1:0] == 2'b11))
        || (waddr_q == ABX_OFF_ACC) || (waddr_q == ABX_OFF_STATUS));
    assign launch = do_write && wr_ok && (waddr_q == ABX_OFF_INSTR);
    assign acc_wr = do_write && wr_ok && (waddr_q == ABX_OFF_ACC) && wstrb_q[0];
    assign st_wr = do_write && wr_ok && (waddr_q == ABX_OFF_STATUS) && wstrb_q[0];

    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        waddr_d = waddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_hold_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_hold_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (do_write) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = wr_ok ? ABX_RESP_OKAY : ABX_RESP_SLVERR;
        end
        if (rvalid_q && s_axi_rready) rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = ABX_RESP_OKAY;
            case (s_axi_araddr)
                ABX_OFF_INSTR: rdata_d = {18'h0_0000, instr_q};
                ABX_OFF_ACC: rdata_d = {24'h00_0000, acc_q};
                ABX_OFF_STATUS: rdata_d = {27'h000_0000, busy, skip_q, z_q, dc_q, c_q};
                ABX_OFF_PINS: rdata_d = {24'h00_0000, pins_sync};
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = ABX_RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_hold_d && !bvalid_d;
        wready_d = !w_hold_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= ABX_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= ABX_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Execution datapath
    always_comb begin
        logic [7:0] opnd;
        logic [7:0] res;
        logic [7:0] lit;
        logic [8:0] sum9;
        logic [4:0] nib5;
        logic bitv;
        st_d = st_q;
        op_d = op_q;
        instr_d = instr_q;
        acc_d = acc_q;
        c_d = c_q;
        dc_d = dc_q;
        z_d = z_q;
        skip_d = skip_q;
        fr_addr_d = fr_addr_q;
        fr_wdata_d = fr_wdata_q;
        fr_we_d = 1'b0;
        // Port register reads the pins, not the latch
        opnd = (fr_addr_q == PORT_ADDR) ? pins_sync : fr_rdata; // RULE10
        lit = wdata_q[7:0];
        res = 8'h00;
        sum9 = 9'h000;
        nib5 = 5'h00;
        bitv = opnd[instr_q[9:7]];
        case (st_q)
            ABX_EX_IDLE: begin
                if (acc_wr) acc_d = wdata_q[7:0];
                if (st_wr) begin
                    c_d = wdata_q[ABX_ST_CARRY];
                    dc_d = wdata_q[ABX_ST_NIBBLE];
                    z_d = wdata_q[ABX_ST_ZERO];
                end
                if (launch) begin
                    instr_d = wdata_q[ABX_IW-1:0];
                    if (skip_q) begin
                        skip_d = 1'b0; // RULE11
                    end else begin
                        op_d = decode(wdata_q[ABX_IW-1:0]);
                        fr_addr_d = wdata_q[6:0];
                        case (op_d)
                            ABX_ADD_IMMEDIATE_OP: begin
                                sum9 = {1'b0, acc_q} + {1'b0, lit}; // RULE1
                                nib5 = {1'b0, acc_q[3:0]} + {1'b0, lit[3:0]};
                                acc_d = sum9[7:0];
                                c_d = sum9[8]; // RULE12
                                dc_d = nib5[4];
                                z_d = (sum9[7:0] == 8'h00);
                            end
                            ABX_AND_IMMEDIATE_OP: begin
                                acc_d = acc_q & lit; // RULE4
                                z_d = ((acc_q & lit) == 8'h00);
                            end
                            ABX_NONE_OP: st_d = ABX_EX_IDLE;
                            default: st_d = ABX_EX_READ;
                        endcase
                    end
                end
            end
            ABX_EX_READ: begin
                st_d = ABX_EX_IDLE;
                case (op_q)
                    ABX_ADD_REGISTER_OP: begin
                        sum9 = {1'b0, acc_q} + {1'b0, opnd}; // RULE2
                        nib5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]};
                        res = sum9[7:0];
                        c_d = sum9[8]; // RULE12
                        dc_d = nib5[4];
                        z_d = (res == 8'h00);
                    end
                    ABX_AND_REGISTER_OP: begin
                        res = acc_q & opnd; // RULE5
                        z_d = (res == 8'h00);
                    end
                    ABX_BIT_FORCE_LOW_OP: begin
                        res = opnd;
                        res[instr_q[9:7]] = 1'b0; // RULE6
                    end
                    ABX_BIT_FORCE_HIGH_OP: begin
                        res = opnd;
                        res[instr_q[9:7]] = 1'b1; // RULE7
                    end
                    ABX_TEST_SKIP_ON_LOW_OP: skip_d = !bitv; // RULE8
                    ABX_TEST_SKIP_ON_HIGH_OP: skip_d = bitv; // RULE9
                    default: res = opnd;
                endcase
                fr_wdata_d = res;
                if (op_q == ABX_ADD_REGISTER_OP || op_q == ABX_AND_REGISTER_OP) begin
                    if (instr_q[ABX_DEST_BIT]) fr_we_d = 1'b1; // RULE3
                    else acc_d = res; // RULE3
                end else if (op_q == ABX_BIT_FORCE_LOW_OP || op_q == ABX_BIT_FORCE_HIGH_OP) begin
                    fr_we_d = 1'b1;
                end
            end
            default: st_d = ABX_EX_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ABX_EX_IDLE;
            op_q <= ABX_NONE_OP;
            instr_q <= ABX_INSTR_RST;
            acc_q <= ABX_ACC_RST;
            c_q <= 1'b0;
            dc_q <= 1'b0;
            z_q <= 1'b0;
            skip_q <= 1'b0;
            fr_addr_q <= '0;
            fr_wdata_q <= '0;
            fr_we_q <= 1'b0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            instr_q <= instr_d;
            acc_q <= acc_d;
            c_q <= c_d;
            dc_q <= dc_d;
            z_q <= z_d;
            skip_q <= skip_d;
            fr_addr_q <= fr_addr_d;
            fr_wdata_q <= fr_wdata_d;
            fr_we_q <= fr_we_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign fr_addr = fr_addr_q;
    assign fr_wdata = fr_wdata_q;
    assign fr_we = fr_we_q;
endmodule : abx_exec
`default_nettype wire

// ===== bench/abx_props.sv
`timescale 1ns/100ps
`default_nettype none
module abx_props
    import abx_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ABX_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [ABX_DW-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [6:0] fr_addr,
    input wire logic fr_we
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    rst_ready_a: assert property ($rose(aresetn) |=> s_axi_awready && s_axi_arready)
        else $error("readies low after reset");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer timing wrong");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##1 s_axi_arready)
        else $error("read release wrong");
    rd_unmap_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > ABX_OFF_PINS
        |=> s_axi_rresp == ABX_RESP_SLVERR && s_axi_rdata == '0)
        else $error("unmapped read not refused");
    wb_pulse_a: assert property (fr_we |=> !fr_we)
        else $error("write-back longer than one cycle");
    wb_cause_a: assert property (fr_we |-> $past(s_axi_bvalid) && $stable(fr_addr))
        else $error("write-back without launch");
    wb_c: cover property (fr_we);
    berr_c: cover property (s_axi_bvalid && s_axi_bresp == ABX_RESP_SLVERR);
    rerr_c: cover property (s_axi_rvalid && s_axi_rresp == ABX_RESP_SLVERR);
endmodule : abx_props
`default_nettype wire

// ===== bench/abx_fmem.sv
`timescale 1ns/100ps
`default_nettype none
module abx_fmem (
    input wire logic aclk,
    input wire logic [6:0] fr_addr,
    input wire logic [7:0] fr_wdata,
    input wire logic fr_we,
    output logic [7:0] fr_rdata
);
    logic [7:0] mem [128];
    // Read is combinational, as the core samples it in the fetch cycle
    assign fr_rdata = mem[fr_addr];
    always @(posedge aclk) begin
        if (fr_we) begin
            mem[fr_addr] <= fr_wdata;
        end
    end
endmodule : abx_fmem
`default_nettype wire

// ===== bench/add_and_bit_ops_exec_tb.sv
`timescale 1ns/100ps
`default_nettype none
module add_and_bit_ops_exec_tb;
    import abx_pkg::*;
    localparam logic [6:0] PA = 7'h05;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, port_pins = '0, fr_wdata, fr_rdata, acc = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'hb4d5_e394;
    logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, fl = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0;
    logic s_axi_rready = '0, skp = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, fr_we;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [6:0] fr_addr;
    logic [13:0] liw = '0;
    logic [7:0] m [128];
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    logic [14:0] fq [$];
    int error_cnt = 0, n_compared = 0;

    always #10 aclk = ~aclk;
    abx_exec #(.PORT_ADDR(PA)) dut (.*);
    abx_fmem u_mem (.*);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        // Leftover notes mean a result never appeared
        chk(34'(fq.size() + bq.size() + rq.size()), 34'h0);
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    // Every wait is bounded so a stuck handshake ends the run
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 50) begin
            error_cnt++;
            summarize();
        end
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        logic aw = 1'h0;
        logic w = 1'h0;
        bq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        // Late bready now and then, so the response must hold
        s_axi_bready <= !d[31];
        while (!(aw && w)) begin
            tick(n);
            if (s_axi_awready) begin
                aw = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wready) begin
                w = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        tick(n);
        while (!s_axi_bvalid) tick(n);
        if (!s_axi_bready) begin
            s_axi_bready <= 1'h1;
            tick(n);
        end
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n = 0;
        rq.push_back(e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= !seed[0];
        tick(n);
        while (!s_axi_arready) tick(n);
        s_axi_arvalid <= 1'h0;
        tick(n);
        while (!s_axi_rvalid) tick(n);
        if (!s_axi_rready) begin
            s_axi_rready <= 1'h1;
            tick(n);
        end
        s_axi_rready <= 1'h0;
        @(posedge aclk);
    endtask : rd

    task automatic wb(input logic [6:0] f, input logic [7:0] v);
        m[f] = v;
        fq.push_back({f, v});
    endtask : wb

    task automatic ex(input logic [13:0] iw);
        logic [6:0] f;
        logic [7:0] v;
        logic [8:0] s;
        f = iw[6:0];
        v = (f == PA) ? port_pins : m[f];
        liw = iw;
        if (skp) begin
            skp = 1'h0;
        end else if (iw[13:12] == ABX_CLS_BIT) begin
            case (iw[11:10])
                ABX_BIT_LOW: wb(f, v & ~(8'h01 << iw[9:7]));
                ABX_BIT_HIGH: wb(f, v | (8'h01 << iw[9:7]));
                ABX_BIT_TST_LOW: skp = !v[iw[9:7]];
                default: skp = v[iw[9:7]];
            endcase
        end else if (iw[13:12] != 2'h2) begin
            // Class 2 words decode to nothing here and change no state
            if (iw[13:12] == ABX_CLS_LIT) v = iw[7:0];
            if (iw[11:8] == ABX_LIT_AND || iw[11:8] == ABX_BYTE_AND) begin
                s = {1'h0, acc & v};
                fl[2] = s[7:0] == '0;
            end else begin
                s = 9'(acc) + 9'(v);
                fl = {s[7:0] == '0, 5'(acc[3:0]) + 5'(v[3:0]) > 5'h0f, s[8]};
            end
            if (iw[13:12] == ABX_CLS_BYTE && iw[ABX_DEST_BIT]) wb(f, s[7:0]);
            else acc = s[7:0];
        end
        wr(ABX_OFF_INSTR, 32'(iw), ABX_RESP_OKAY);
    endtask : ex

    task automatic ck();
        rd(ABX_OFF_ACC, {ABX_RESP_OKAY, 24'h0, acc});
        rd(ABX_OFF_STATUS, {ABX_RESP_OKAY, 28'h0, skp, fl});
        rd(ABX_OFF_INSTR, {ABX_RESP_OKAY, 18'h0, liw});
    endtask : ck

    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (fr_we) chk(34'({fr_addr, fr_wdata}), 34'(fq.pop_front()));
    end

    initial begin
        logic [31:0] a;
        logic [31:0] r;
        logic [6:0] f;
        for (int i = 0; i < 128; i++) begin
            m[i] = 8'(rnd());
            u_mem.mem[i] = m[i];
        end
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        ck();
        rd(8'h10, {ABX_RESP_SLVERR, 32'h0});
        wr(ABX_OFF_PINS, 32'h0, ABX_RESP_SLVERR);
        ex(14'h2a5c);
        // Partial strobes: instruction refused, accumulator left alone
        s_axi_wstrb <= 4'hc;
        wr(ABX_OFF_INSTR, 32'h0000_3e12, ABX_RESP_SLVERR);
        wr(ABX_OFF_ACC, 32'h0000_00a5, ABX_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        ck();
        // Eight kinds in turn, so each test op but the last is followed by an op it may discard
        for (int i = 0; i < 64; i++) begin
            a = rnd();
            r = rnd();
            if (i < 8) begin
                a[7:0] = 8'hff;
                r[7:0] = 8'hff;
            end
            port_pins <= 8'(rnd());
            f = (r[12:11] == '0) ? PA : r[6:0];
            acc = a[7:0];
            wr(ABX_OFF_ACC, a, ABX_RESP_OKAY);
            fl = r[15:13];
            wr(ABX_OFF_STATUS, 32'(r[15:13]), ABX_RESP_OKAY);
            rd(ABX_OFF_PINS, {ABX_RESP_OKAY, 24'h0, port_pins});
            if (i % 8 < 2) ex({ABX_CLS_LIT, i[0] ? ABX_LIT_AND : {ABX_LIT_ADD, r[8]}, r[7:0]});
            else if (i % 8 < 4) ex({ABX_CLS_BYTE, i[0] ? ABX_BYTE_AND : ABX_BYTE_ADD, r[7], f});
            else ex({ABX_CLS_BIT, 2'(i), r[10:8], f});
            ck();
        end
        summarize();
    end
endmodule : add_and_bit_ops_exec_tb
bind abx_exec abx_props u_props (.*);
`default_nettype wire
